// >>> rtl/nav_text_map.vh
// constants for the navigation text formatter
`ifndef NAV_TEXT_MAP_VH
`define NAV_TEXT_MAP_VH
// message kinds on msg_kind
`define KIND_RAW 2'h0
`define KIND_ALM 2'h1
`define KIND_EPH 2'h2
// ascii characters
`define CH_STX 8'h02
`define CH_ETX 8'h03
`define CH_CR 8'h0D
`define CH_LF 8'h0A
`define CH_COMMA 8'h2C
`define CH_BANG 8'h21
`define CH_ALM 8'h41
`define CH_EPH 8'h45
`define CH_DOT 8'h2E
`define CH_MINUS 8'h2D
`define CH_ZERO 8'h30
`define CH_ALPHA 8'h37
// quality byte field positions
`define LC_MSB 4
`define PHCLS_LSB 5
`define MP_UNKNOWN 4'hF
// phase error thresholds, units of 1e-5 cycle
`define PH_T0 17'h00187
`define PH_T1 17'h002B8
`define PH_T2 17'h004D7
`define PH_T3 17'h008A0
`define PH_T4 17'h00F5D
`define PH_T5 17'h01B5E
`define PH_T6 17'h030C0
// pseudorange error thresholds, units of 1e-3
`define PR_T0 16'h0014
`define PR_T1 16'h001E
`define PR_T2 16'h002D
`define PR_T3 16'h0042
`define PR_T4 16'h0063
`define PR_T5 16'h0094
`define PR_T6 16'h00DC
`define PR_T7 16'h0149
`define PR_T8 16'h01EB
`define PR_T9 16'h02DC
`define PR_T10 16'h0444
`define PR_T11 16'h065D
`define PR_T12 16'h097E
`define PR_T13 16'h0E29
`define PR_T14 16'h1521
// one cycle and its half, in thousandths of a cycle
`define DEV_MOD 32'h000003E8
`define DEV_HALF 32'h000001F4
// 1e8 cycles of L2 in thousandths of a cycle
`define L2_MOD 41'h0174876E800
// almanac satellites up to this number come from subframe 5
`define ALM_SF5_MAX 8'h18
`define DEC_TOP 4'hB
`endif

// >>> rtl/nav_text_formatter.v
// ascii formatter for raw tail, almanac and ephemeris messages
// What this block does
// [R1] quality bytes as two hex chars, high first
// [R2] l2 byte bits 0-4: loss counter mod 32
// [R3] l2 byte bits 5-7: phase error class
// [R4] p/y byte bits 0-3: multipath, 1111 unknown
// [R5] p/y byte bits 4-7: pseudorange error class
// [R6] phase deviation in millicycles, centred mod one
// [R7] l2 phase in millicycles, wraps at 1e8
// [R8] almanac: stx, time, params, one line, etx
// [R9] time line: id, week, comma, seconds
// [R10] week counted from 1980, rollover resolved
// [R11] almanac params: satellite, then reference week
// [R12] almanac words 3-10 from subframe 4/5
// [R13] word as six hex chars, bits 1-4 first
// [R14] almanac words ascending, commas, end of line
// [R15] ephemeris: time, satellite, three lines, framed
// [R16] ephemeris lines from subframes 1, 2, 3
// [R17] ephemeris lines: eight words, commas, eol
// [R18] hex digits 0-9 and uppercase A-F
`timescale 1ns/100ps
`include "nav_text_map.vh"
module nav_text_formatter (
  input wire clock, // system clock, 200 MHz
  input wire rst_n, // synchronous reset, active low
  input wire start, // pulse: begin a message
  input wire [1:0] msg_kind, // message kind, taken with start
  output reg busy, // high while a message is emitted
  input wire [15:0] gps_week, // full gps week number
  input wire [31:0] gps_tow, // time of week in tenths of s
  input wire [7:0] sv_num, // satellite number
  input wire [15:0] alm_week, // almanac reference week
  input wire word_wr, // pulse: store a navigation word
  input wire [2:0] word_sf, // subframe 1 to 5
  input wire [3:0] word_num, // word 3 to 10
  input wire [23:0] word_data, // word bits 1-24, bit 1 at msb
  input wire cont_lost, // pulse: l2 phase continuity lost
  input wire [16:0] phase_err, // l2 phase error, 1e-5 cycle
  input wire [15:0] pr_err, // p/y pseudorange error, 1e-3
  input wire [3:0] mp_err, // multipath error indicator
  input wire mp_valid, // multipath indicator determined
  input wire [31:0] dev_in, // l1 p/y - c/a phase, millicycles
  input wire [31:0] cdev_l1, // p l1 - c/a code dev, 1e-10 s
  input wire [31:0] cdev_l2, // p l2 - c/a code dev, 1e-10 s
  input wire l2_upd, // pulse: add l2_delta to l2 phase
  input wire [31:0] l2_delta, // signed l2 phase step, millicycles
  input wire [31:0] l2_speed, // l2 carrier speed, millicycles
  output reg [7:0] out_data, // ascii character
  output reg out_valid, // character valid
  input wire out_ready // consumer takes the character
);

  // engine states, one-hot
  localparam S_IDLE = 6'h01;
  localparam S_STEP = 6'h02;
  localparam S_DEC = 6'h04;
  localparam S_HEX = 6'h08;
  localparam S_LF = 6'h10;
  localparam S_SEP = 6'h20;
  // script operations
  localparam OP_CHR = 3'h0;
  localparam OP_DEC = 3'h1;
  localparam OP_HEX8 = 3'h2;
  localparam OP_EOL = 3'h3;
  localparam OP_WORDS = 3'h4;
  localparam OP_NOP = 3'h5;
  localparam OP_END = 3'h6;

  reg [5:0] st_q; // engine state
  reg [1:0] kind_q; // message kind in progress
  reg [4:0] step_q; // script position
  reg [40:0] rem_q; // decimal remainder
  reg [3:0] pw_q; // current power of ten
  reg [3:0] dig_q; // current decimal digit
  reg started_q; // a digit has gone out
  reg dot_q; // a point is still due before last digit
  reg sgn_q; // minus sign still due
  reg [23:0] hexv_q; // value being sent in hex
  reg [2:0] nib_q; // hex characters left
  reg words_q; // inside a data line block
  reg [1:0] line_q; // data line number
  reg [2:0] word_q; // word in line, 0 is word 3
  reg [4:0] lc_q; // loss of continuity counter
  reg [40:0] l2_acc_q; // l2 phase accumulator
  reg [23:0] mem_q [0:39]; // five subframes of eight words
  wire free; // output slot can take a character
  assign free = !out_valid || out_ready;

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // nibble to ascii hex character
  function [7:0] hex_ch;
    input [3:0] n;
    begin
      if (n < 4'hA) begin
        hex_ch = `CH_ZERO + {4'h0, n}; // [R18]
      end else begin
        hex_ch = `CH_ALPHA + {4'h0, n}; // [R18]
      end
    end
  endfunction

  // power of ten table
  function [40:0] pow10;
    input [3:0] i;
    begin
      case (i)
        4'h0: pow10 = 41'h00000000001;
        4'h1: pow10 = 41'h0000000000A;
        4'h2: pow10 = 41'h00000000064;
        4'h3: pow10 = 41'h000000003E8;
        4'h4: pow10 = 41'h00000002710;
        4'h5: pow10 = 41'h000000186A0;
        4'h6: pow10 = 41'h000000F4240;
        4'h7: pow10 = 41'h00000989680;
        4'h8: pow10 = 41'h00005F5E100;
        4'h9: pow10 = 41'h0003B9ACA00;
        4'hA: pow10 = 41'h002540BE400;
        default: pow10 = 41'h0174876E800;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // quality bytes

  reg [2:0] ph_cls; // phase error class
  reg [3:0] pr_cls; // pseudorange error class
  wire [7:0] q_l2; // l2 carrier quality byte
  wire [7:0] q_py; // p/y code quality byte

  // classify errors against the threshold ladders
  always @* begin
    if (phase_err <= `PH_T0) ph_cls = 3'h0; // [R3]
    else if (phase_err <= `PH_T1) ph_cls = 3'h1;
    else if (phase_err <= `PH_T2) ph_cls = 3'h2;
    else if (phase_err <= `PH_T3) ph_cls = 3'h3;
    else if (phase_err <= `PH_T4) ph_cls = 3'h4;
    else if (phase_err <= `PH_T5) ph_cls = 3'h5;
    else if (phase_err <= `PH_T6) ph_cls = 3'h6;
    else ph_cls = 3'h7; // above the top step
    if (pr_err <= `PR_T0) pr_cls = 4'h0; // [R5]
    else if (pr_err <= `PR_T1) pr_cls = 4'h1;
    else if (pr_err <= `PR_T2) pr_cls = 4'h2;
    else if (pr_err <= `PR_T3) pr_cls = 4'h3;
    else if (pr_err <= `PR_T4) pr_cls = 4'h4;
    else if (pr_err <= `PR_T5) pr_cls = 4'h5;
    else if (pr_err <= `PR_T6) pr_cls = 4'h6;
    else if (pr_err <= `PR_T7) pr_cls = 4'h7;
    else if (pr_err <= `PR_T8) pr_cls = 4'h8;
    else if (pr_err <= `PR_T9) pr_cls = 4'h9;
    else if (pr_err <= `PR_T10) pr_cls = 4'hA;
    else if (pr_err <= `PR_T11) pr_cls = 4'hB;
    else if (pr_err <= `PR_T12) pr_cls = 4'hC;
    else if (pr_err <= `PR_T13) pr_cls = 4'hD;
    else if (pr_err <= `PR_T14) pr_cls = 4'hE;
    else pr_cls = 4'hF; // above the top step
  end

  assign q_l2 = {ph_cls, lc_q}; // [R2] [R3]
  assign q_py = {pr_cls, mp_valid ? mp_err : `MP_UNKNOWN}; // [R4] [R5]

  ////////////////////////////////////////////////////////////////////////
  // measurement state: loss counter, l2 phase, word store

  wire [40:0] l2_sum; // accumulator plus step
  assign l2_sum = l2_acc_q + {{9{l2_delta[31]}}, l2_delta};

  // counter wraps by width; phase wraps into [0, 1e8 cycles)
  always @(posedge clock) begin
    if (!rst_n) begin
      lc_q <= 5'h00;
      l2_acc_q <= 41'h00000000000;
    end else begin
      if (cont_lost) begin
        lc_q <= lc_q + 5'h01; // [R2]
      end
      if (l2_upd) begin
        if (l2_sum[40]) begin
          l2_acc_q <= l2_sum + `L2_MOD; // [R7]
        end else if (l2_sum >= `L2_MOD) begin
          l2_acc_q <= l2_sum - `L2_MOD; // [R7]
        end else begin
          l2_acc_q <= l2_sum;
        end
      end
    end
  end

  wire [5:0] wr_idx; // store slot of an incoming word
  assign wr_idx = {word_sf - 3'h1, 3'h0} + {3'h0, word_num[2:0] - 3'h3};

  // one flip-flop word per subframe and word slot
  genvar gi;
  generate
    for (gi = 0; gi < 40; gi = gi + 1) begin : g_word
      always @(posedge clock) begin
        if (!rst_n) begin
          mem_q[gi] <= 24'h000000;
        end else if (word_wr && wr_idx == gi) begin
          mem_q[gi] <= word_data;
        end
      end
    end
  endgenerate

  // subframe of the word being sent
  wire [2:0] rd_sf;
  assign rd_sf = (kind_q == `KIND_EPH) ? {1'b0, line_q} + 3'h1 : // [R16]
    (sv_num <= `ALM_SF5_MAX) ? 3'h5 : 3'h4; // [R12]
  wire [5:0] rd_base; // first slot of that subframe
  assign rd_base = {rd_sf - 3'h1, 3'h0};
  wire [2:0] nxt_word; // next word position
  assign nxt_word = word_q + 3'h1;

  ////////////////////////////////////////////////////////////////////////
  // decimal sources

  wire signed [31:0] dev_mod; // deviation reduced to one cycle
  reg signed [31:0] dev_c; // deviation centred on zero
  assign dev_mod = $signed(dev_in) % $signed(`DEV_MOD);
  always @* begin
    if (dev_mod >= $signed(`DEV_HALF)) begin
      dev_c = dev_mod - $signed(`DEV_MOD); // [R6]
    end else if (dev_mod < -$signed(`DEV_HALF)) begin
      dev_c = dev_mod + $signed(`DEV_MOD); // [R6]
    end else begin
      dev_c = dev_mod;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // message script

  reg [2:0] op_c; // operation at this step
  reg [7:0] ch_c; // fixed character
  reg [40:0] val_c; // signed decimal value
  reg dot_c; // decimal has one fractional digit
  reg [7:0] qb_c; // quality byte for hex output
  reg [1:0] last_c; // last data line number

  always @* begin
    op_c = OP_END;
    ch_c = `CH_COMMA;
    val_c = 41'h00000000000;
    dot_c = 1'b0;
    qb_c = q_l2;
    last_c = (kind_q == `KIND_EPH) ? 2'h2 : 2'h0; // [R15] [R8]
    if (kind_q == `KIND_RAW) begin
      // deviation, two code deviations, l2 phase, speed, two bytes
      case (step_q)
        5'h00: begin
          op_c = OP_DEC;
          val_c = {{9{dev_c[31]}}, dev_c}; // [R6]
        end
        5'h02: begin
          op_c = OP_DEC;
          val_c = {{9{cdev_l1[31]}}, cdev_l1};
        end
        5'h04: begin
          op_c = OP_DEC;
          val_c = {{9{cdev_l2[31]}}, cdev_l2};
        end
        5'h06: begin
          op_c = OP_DEC;
          val_c = l2_acc_q; // [R7]
        end
        5'h08: begin
          op_c = OP_DEC;
          val_c = {{9{l2_speed[31]}}, l2_speed};
        end
        5'h0A: op_c = OP_HEX8; // [R1]
        5'h0C: begin
          op_c = OP_HEX8; // [R1]
          qb_c = q_py;
        end
        5'h0D: op_c = OP_EOL;
        5'h01, 5'h03, 5'h05, 5'h07, 5'h09, 5'h0B: op_c = OP_CHR;
        default: op_c = OP_END;
      endcase
    end else begin
      case (step_q)
        5'h00: begin
          op_c = OP_CHR;
          ch_c = `CH_STX; // [R8] [R15]
        end
        5'h01: op_c = OP_EOL;
        5'h02: begin
          op_c = OP_CHR;
          ch_c = `CH_BANG; // [R9]
        end
        5'h03: begin
          op_c = OP_CHR;
          ch_c = (kind_q == `KIND_EPH) ? `CH_EPH : `CH_ALM; // [R9]
        end
        5'h04, 5'h06: op_c = OP_CHR;
        5'h05: begin
          op_c = OP_DEC;
          val_c = {25'h0000000, gps_week}; // [R9] [R10]
        end
        5'h07: begin
          op_c = OP_DEC;
          val_c = {9'h000, gps_tow}; // [R9]
          dot_c = 1'b1;
        end
        5'h08, 5'h0C: op_c = OP_EOL;
        5'h09: begin
          op_c = OP_DEC;
          val_c = {33'h000000000, sv_num}; // [R11] [R15]
        end
        5'h0A: op_c = (kind_q == `KIND_EPH) ? OP_NOP : OP_CHR;
        5'h0B: begin
          op_c = (kind_q == `KIND_EPH) ? OP_NOP : OP_DEC;
          val_c = {25'h0000000, alm_week}; // [R11]
        end
        5'h0D: op_c = OP_WORDS; // [R14] [R17]
        5'h0E: begin
          op_c = OP_CHR;
          ch_c = `CH_ETX; // [R8] [R15]
        end
        default: op_c = OP_END;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // character engine; leaves idle on start, else advances only when the output slot is free

  always @(posedge clock) begin
    if (!rst_n) begin
      st_q <= S_IDLE;
      kind_q <= `KIND_RAW;
      step_q <= 5'h00;
      rem_q <= 41'h00000000000;
      pw_q <= 4'h0;
      dig_q <= 4'h0;
      started_q <= 1'b0;
      dot_q <= 1'b0;
      sgn_q <= 1'b0;
      hexv_q <= 24'h000000;
      nib_q <= 3'h0;
      words_q <= 1'b0;
      line_q <= 2'h0;
      word_q <= 3'h0;
      busy <= 1'b0;
      out_data <= 8'h00;
      out_valid <= 1'b0;
    end else begin
      if (out_ready) begin
        out_valid <= 1'b0; // character taken
      end
      case (st_q)
        S_IDLE: begin
          if (start) begin
            kind_q <= msg_kind;
            step_q <= 5'h00;
            busy <= 1'b1;
            st_q <= S_STEP;
          end
        end
        S_STEP: begin
          if (free) begin
            case (op_c)
              OP_CHR: begin
                out_data <= ch_c;
                out_valid <= 1'b1;
                step_q <= step_q + 5'h01;
              end
              OP_EOL: begin
                out_data <= `CH_CR;
                out_valid <= 1'b1;
                st_q <= S_LF;
              end
              OP_DEC: begin
                sgn_q <= val_c[40];
                rem_q <= val_c[40] ? -val_c : val_c;
                pw_q <= `DEC_TOP;
                dig_q <= 4'h0;
                started_q <= 1'b0;
                dot_q <= dot_c;
                st_q <= S_DEC;
              end
              OP_HEX8: begin
                hexv_q <= {qb_c, 16'h0000}; // [R1]
                nib_q <= 3'h2;
                st_q <= S_HEX;
              end
              OP_WORDS: begin
                words_q <= 1'b1;
                line_q <= 2'h0;
                word_q <= 3'h0;
                hexv_q <= mem_q[rd_base];
                nib_q <= 3'h6; // [R13]
                st_q <= S_HEX;
              end
              OP_NOP: step_q <= step_q + 5'h01;
              default: begin
                busy <= 1'b0;
                st_q <= S_IDLE;
              end
            endcase
          end
        end
        S_DEC: begin
          if (free) begin
            if (sgn_q) begin
              out_data <= `CH_MINUS;
              out_valid <= 1'b1;
              sgn_q <= 1'b0;
            end else if (rem_q >= pow10(pw_q)) begin
              rem_q <= rem_q - pow10(pw_q);
              dig_q <= dig_q + 4'h1;
            end else if (pw_q == 4'h0 && dot_q) begin
              if (!started_q) begin
                out_data <= `CH_ZERO; // keep a digit before the point
                started_q <= 1'b1;
              end else begin
                out_data <= `CH_DOT;
                dot_q <= 1'b0;
              end
              out_valid <= 1'b1;
            end else begin
              if (started_q || dig_q != 4'h0 || pw_q == 4'h0) begin
                out_data <= `CH_ZERO + {4'h0, dig_q};
                out_valid <= 1'b1;
                started_q <= 1'b1;
              end
              dig_q <= 4'h0;
              if (pw_q == 4'h0) begin
                step_q <= step_q + 5'h01;
                st_q <= S_STEP;
              end else begin
                pw_q <= pw_q - 4'h1;
              end
            end
          end
        end
        S_HEX: begin
          if (free) begin
            out_data <= hex_ch(hexv_q[23:20]); // [R13] [R1]
            out_valid <= 1'b1;
            hexv_q <= {hexv_q[19:0], 4'h0};
            nib_q <= nib_q - 3'h1;
            if (nib_q == 3'h1) begin
              if (!words_q) begin
                step_q <= step_q + 5'h01;
                st_q <= S_STEP;
              end else if (word_q == 3'h7) begin
                st_q <= S_SEP; // line ends after word 10
              end else begin
                st_q <= S_SEP;
              end
            end
          end
        end
        S_SEP: begin
          if (free) begin
            if (word_q == 3'h7) begin
              out_data <= `CH_CR; // [R14] [R17]
              st_q <= S_LF;
            end else begin
              out_data <= `CH_COMMA; // [R14] [R17]
              word_q <= nxt_word;
              hexv_q <= mem_q[rd_base + {3'h0, nxt_word}];
              nib_q <= 3'h6;
              st_q <= S_HEX;
            end
            out_valid <= 1'b1;
          end
        end
        S_LF: begin
          if (free) begin
            out_data <= `CH_LF;
            out_valid <= 1'b1;
            if (words_q && line_q != last_c) begin
              line_q <= line_q + 2'h1; // [R16]
              word_q <= 3'h0;
              hexv_q <= mem_q[rd_base + 6'h08];
              nib_q <= 3'h6;
              st_q <= S_HEX;
            end else begin
              words_q <= 1'b0;
              line_q <= 2'h0; // next message starts at line one
              step_q <= step_q + 5'h01;
              st_q <= S_STEP;
            end
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

endmodule

// >>> testbench/nav_text_props.sv
// concurrent checks on the formatter's ports
`timescale 1ns/100ps
`include "nav_text_map.vh"
module nav_text_props (
  input wire clock, // system clock
  input wire rst_n, // synchronous reset, active low
  input wire start, // message request
  input wire [1:0] msg_kind, // message kind
  input wire busy, // message in progress
  input wire [7:0] out_data, // ascii character
  input wire out_valid, // character valid
  input wire out_ready // consumer ready
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////
  // a stalled character holds its value until taken
  a_stall_holds: assert property (out_valid && !out_ready |=>
    out_valid && $stable(out_data)) else $error("stalled char changed");
  // an accepted request raises busy next edge
  a_start_busy: assert property (start && !busy |=> busy)
    else $error("busy did not rise");
  // nothing is offered outside a message
  a_idle_quiet: assert property (!busy |-> !out_valid)
    else $error("char offered while idle");
  // hex letters are upper case only
  a_hex_upper: assert property (out_valid |->
    !(out_data >= 8'h61 && out_data <= 8'h66)) else $error("lower hex");
  // almanac opens with start-of-text
  a_alm_stx: assert property (start && !busy && msg_kind == `KIND_ALM
    |-> ##2 out_valid && out_data == `CH_STX) else $error("no stx");
  // ephemeris opens with start-of-text
  a_eph_stx: assert property (start && !busy && msg_kind == `KIND_EPH
    |-> ##2 out_valid && out_data == `CH_STX) else $error("no stx");
  // raw tail opens with a number: nothing in the stx slot
  a_raw_plain: assert property (start && !busy && msg_kind == `KIND_RAW
    |-> ##2 !out_valid) else $error("raw framed");
  // end-of-text closes the message within two edges
  a_etx_end: assert property (out_valid && out_ready &&
    out_data == `CH_ETX |=> !out_valid ##[0:1] !busy)
    else $error("busy after etx");
  // carriage return is followed by line feed
  a_eol_pair: assert property (out_valid && out_ready &&
    out_data == `CH_CR |=> out_valid && out_data == `CH_LF)
    else $error("cr without lf");
endmodule
bind nav_text_formatter nav_text_props u_nav_text_props (.clock(clock),
  .rst_n(rst_n), .start(start), .msg_kind(msg_kind), .busy(busy),
  .out_data(out_data), .out_valid(out_valid), .out_ready(out_ready));

// >>> testbench/host_reader.sv
// host model reading the character stream
`timescale 1ns/100ps
module host_reader (
  input wire clock, // system clock
  input wire [7:0] out_data, // ascii character
  input wire out_valid, // character valid
  output reg out_ready, // host takes the character
  input wire slow // stall two cycles of three
);
  reg [7:0] got[$]; // characters received
  reg [1:0] phase_q = 2'h0; // stall pattern counter
  initial out_ready = 1'b0;
  ////////////////////////////////////////////////////////////////////
  // ready changes on the falling edge, away from sampling
  always @(negedge clock) begin
    phase_q <= (phase_q == 2'h2) ? 2'h0 : phase_q + 2'h1;
    out_ready <= slow ? (phase_q == 2'h1) : 1'b1;
  end
  // capture on the rising edge handshake
  always @(posedge clock) begin
    if (out_valid && out_ready) begin
      got.push_back(out_data);
    end
  end
endmodule

// >>> testbench/nav_text_formatter_tb_top.sv
// self-checking bench for the navigation text formatter
`timescale 1ns/100ps
`include "nav_text_map.vh"
module nav_text_formatter_tb_top;
  reg clock = 1'b0; // 200 MHz clock
  reg rst_n = 1'b0; // reset, active low
  reg start = 1'b0, word_wr = 1'b0, cont_lost = 1'b0, l2_upd = 1'b0;
  reg mp_valid = 1'b0, slow = 1'b0; // multipath known; host stalls
  reg [1:0] msg_kind = 2'h0; // message kind
  reg [15:0] gps_week = 16'h0835, alm_week = 16'h0834, pr_err = 16'h0;
  reg [31:0] gps_tow = 32'h003F3F52; // 414497.8 s
  reg [7:0] sv_num = 8'h04; // satellite number
  reg [2:0] word_sf = 3'h1; // subframe
  reg [3:0] word_num = 4'h3, mp_err = 4'h0; // word index, multipath
  reg [23:0] word_data = 24'h0; // navigation word
  reg [16:0] phase_err = 17'h0; // l2 phase error
  reg [31:0] dev_in = 32'h0, cdev_l1 = 32'h0, cdev_l2 = 32'h0;
  reg [31:0] l2_delta = 32'h0, l2_speed = 32'h0;
  wire busy, out_valid, out_ready; // design status and handshake
  wire [7:0] out_data; // ascii character
  reg [7:0] exp_q[$]; // expected characters
  integer fails = 0, checks_done = 0, cycles = 0;
  always #2.5 clock = ~clock;
  nav_text_formatter u_nav_text_formatter (.clock(clock), .rst_n(rst_n),
    .start(start), .msg_kind(msg_kind), .busy(busy), .gps_week(gps_week),
    .gps_tow(gps_tow), .sv_num(sv_num), .alm_week(alm_week),
    .word_wr(word_wr), .word_sf(word_sf), .word_num(word_num),
    .word_data(word_data), .cont_lost(cont_lost), .phase_err(phase_err),
    .pr_err(pr_err), .mp_err(mp_err), .mp_valid(mp_valid), .dev_in(dev_in),
    .cdev_l1(cdev_l1), .cdev_l2(cdev_l2), .l2_upd(l2_upd),
    .l2_delta(l2_delta), .l2_speed(l2_speed), .out_data(out_data),
    .out_valid(out_valid), .out_ready(out_ready));
  host_reader u_host_reader (.clock(clock), .out_data(out_data),
    .out_valid(out_valid), .out_ready(out_ready), .slow(slow));
  ////////////////////////////////////////////////////////////////////
  // compare tasks and expected-stream builders
  task check8(input [7:0] got, input [7:0] exp);
    checks_done = checks_done + 1;
    if (got !== exp) begin
      fails = fails + 1;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task check_n(input integer got, input integer exp);
    checks_done = checks_done + 1;
    if (got !== exp) begin
      fails = fails + 1;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task check1(input got, input exp);
    checks_done = checks_done + 1;
    if (got !== exp) begin
      fails = fails + 1;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task put_s(input string s);
    foreach (s[i]) exp_q.push_back(s[i]);
  endtask
  task put_dec(input longint v);
    put_s($sformatf("%0d", v));
  endtask
  task put_eol;
    exp_q.push_back(`CH_CR);
    exp_q.push_back(`CH_LF);
  endtask
  // word pattern tagged by its subframe and index
  function [23:0] wd(input [2:0] sf, input [3:0] n);
    wd = {4'hA, 1'b0, sf, n, 12'hF0C};
  endfunction
  // one data line: words 3..10, comma separated, then eol
  task put_line(input [2:0] sf);
    integer n, k;
    reg [23:0] w;
    for (n = 3; n <= 10; n = n + 1) begin
      w = wd(sf, n);
      for (k = 5; k >= 0; k = k - 1) begin
        exp_q.push_back(w[k*4+:4] < 10 ? 8'h30 + w[k*4+:4]
          : 8'h37 + w[k*4+:4]);
      end
      if (n < 10) exp_q.push_back(`CH_COMMA);
    end
    put_eol;
  endtask
  task put_time(input string id);
    put_s(id);
    put_dec(gps_week);
    exp_q.push_back(`CH_COMMA);
    put_dec(gps_tow / 10);
    exp_q.push_back(`CH_DOT);
    put_dec(gps_tow % 10);
    put_eol;
  endtask
  // issue one message, wait for its end, compare the whole stream
  task run_msg(input [1:0] kind);
    integer k;
    u_host_reader.got.delete();
    @(negedge clock);
    start = 1'b1;
    msg_kind = kind;
    @(negedge clock);
    start = 1'b0;
    check1(busy, 1'b1);
    k = 0;
    while (busy !== 1'b0 && k < 20000) begin
      @(negedge clock);
      k = k + 1;
    end
    check1(busy, 1'b0);
    check_n(u_host_reader.got.size(), exp_q.size());
    foreach (exp_q[i]) check8(u_host_reader.got[i], exp_q[i]);
    exp_q.delete();
  endtask
  task pulse_loss(input integer cnt);
    repeat (cnt) begin
      @(negedge clock);
      cont_lost = 1'b1;
      @(negedge clock);
      cont_lost = 1'b0;
    end
  endtask
  task pulse_l2(input [31:0] d);
    @(negedge clock);
    l2_upd = 1'b1;
    l2_delta = d;
    @(negedge clock);
    l2_upd = 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////
  // scenarios
  task load_words;
    integer s, n;
    for (s = 1; s <= 5; s = s + 1) begin
      for (n = 3; n <= 10; n = n + 1) begin
        @(negedge clock);
        word_wr = 1'b1;
        word_sf = s;
        word_num = n;
        word_data = wd(s, n);
      end
    end
    @(negedge clock);
    word_wr = 1'b0;
  endtask
  task test_almanac(input [7:0] sv, input [2:0] sf, input st);
    slow = st;
    sv_num = sv;
    exp_q.push_back(`CH_STX);
    put_eol;
    put_time("!A,");
    put_dec(sv);
    exp_q.push_back(`CH_COMMA);
    put_dec(alm_week);
    put_eol;
    put_line(sf);
    exp_q.push_back(`CH_ETX);
    run_msg(`KIND_ALM);
  endtask
  task test_ephemeris;
    slow = 1'b1;
    exp_q.push_back(`CH_STX);
    put_eol;
    put_time("!E,");
    put_dec(sv_num);
    put_eol;
    put_line(3'h1);
    put_line(3'h2);
    put_line(3'h3);
    exp_q.push_back(`CH_ETX);
    run_msg(`KIND_EPH);
  endtask
  task test_raw(input longint dv, input longint l2, input string q);
    slow = 1'b0;
    put_dec(dv);
    put_s($sformatf(",%0d,%0d,", $signed(cdev_l1), $signed(cdev_l2)));
    put_dec(l2);
    put_s($sformatf(",%0d,", $signed(l2_speed)));
    put_s(q);
    put_eol;
    run_msg(`KIND_RAW);
  endtask
  ////////////////////////////////////////////////////////////////////
  // cycle ceiling against hangs
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      fails = fails + 1;
      end_sim;
    end
  end
  task end_sim;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (4) @(negedge clock);
    rst_n = 1'b1;
    load_words;
    test_almanac(8'h04, 3'h5, 1'b0);
    test_almanac(8'h1E, 3'h4, 1'b1);
    sv_num = 8'h0A;
    test_ephemeris;
    test_ephemeris;
    // loss 33 -> 1, phase 392 -> class 1, pr above top, mp unknown
    pulse_loss(33);
    phase_err = 17'h00188;
    pr_err = 16'h1522;
    mp_err = 4'h3;
    dev_in = 32'd1700;
    cdev_l1 = -32'sd23;
    cdev_l2 = 32'sd50;
    l2_speed = 32'sd7;
    pulse_l2(-32'sd5);
    test_raw(-300, 64'd99999999995, "21,FF");
    // loss wraps to 0, lowest classes, determined multipath
    pulse_loss(31);
    phase_err = 17'h00187;
    pr_err = 16'h0014;
    mp_valid = 1'b1;
    dev_in = 32'd500;
    pulse_l2(32'sd10);
    test_raw(-500, 5, "00,03");
    end_sim;
  end
endmodule
